// File: inc/pfmux_pkg.sv
/*
  Constants, types and decode functions for the port 3 to 5 pin function mux.
  Assumes one system clock and APB register access with 32-bit data.
*/
package pfmux_pkg;

  // ==========================================================================
  // Sizes and register map (word indexes, byte address is four times these)
  localparam int          PIN_CNT        = 20;
  localparam int          REG_CNT        = 6;
  localparam logic [29:0] IDX_P3_LOW     = 30'h52a6;
  localparam logic [29:0] IDX_P3_HIGH    = 30'h52a7;
  localparam logic [29:0] IDX_P4_LOW     = 30'h52a8;
  localparam logic [29:0] IDX_P4_UPPER   = 30'h52a9;
  localparam logic [29:0] IDX_P5_LOW     = 30'h52aa;
  localparam logic [29:0] IDX_P5_UPPER   = 30'h52ab;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  MASK_FULL      = 8'hff;
  localparam logic [7:0]  MASK_LOW_NIB   = 8'h0f;
  localparam int          FIRST_P5_REG   = 4;
  localparam int          PIN_P45        = 13;

  // ==========================================================================
  // Field codes
  localparam logic [1:0]  CODE_0         = 2'h0;
  localparam logic [1:0]  CODE_1         = 2'h1;
  localparam logic [1:0]  CODE_2         = 2'h2;

  typedef enum logic [1:0] {SLOT_NONE, SLOT_PORT, SLOT_A, SLOT_B} pfmux_slot_e;
  typedef enum logic [1:0] {KIND_A, KIND_AB, KIND_DBG} pfmux_kind_e;

  // ==========================================================================
  // Pin index order: 0..7 port 3, 8..13 port 4, 14..19 port 5.
  // Slot A is the code 1 function (code 0 on debug pins), slot B code 2.
  function automatic pfmux_kind_e pfmux_kind(input int pin);
    case (pin)
      0:       pfmux_kind = KIND_A;   // R04
      1:       pfmux_kind = KIND_AB;  // R03
      2:       pfmux_kind = KIND_AB;  // R02
      3:       pfmux_kind = KIND_AB;  // R01
      4:       pfmux_kind = KIND_AB;  // R06
      5, 6, 7: pfmux_kind = KIND_DBG; // R05
      8:       pfmux_kind = KIND_AB;  // R10
      9:       pfmux_kind = KIND_AB;  // R09
      10:      pfmux_kind = KIND_AB;  // R08
      11:      pfmux_kind = KIND_AB;  // R07
      12:      pfmux_kind = KIND_AB;  // R13
      13:      pfmux_kind = KIND_A;   // R11
      default: pfmux_kind = KIND_A;   // R14 R15
    endcase
  endfunction

  // Reserved codes map to no slot, so the pin floats
  function automatic pfmux_slot_e pfmux_slot(input pfmux_kind_e kind, input logic [1:0] code);
    if (kind == KIND_DBG)
      pfmux_slot = (code == CODE_0) ? SLOT_A : (code == CODE_1) ? SLOT_PORT : SLOT_NONE;
    else if (code == CODE_0)
      pfmux_slot = SLOT_PORT;
    else if (code == CODE_1)
      pfmux_slot = SLOT_A;
    else if (code == CODE_2 && kind == KIND_AB)
      pfmux_slot = SLOT_B;
    else
      pfmux_slot = SLOT_NONE;
  endfunction

  // Idle level {slot B, slot A} fed to a peripheral whose pin is elsewhere;
  // active-low request, trigger and select inputs idle high
  function automatic logic [1:0] pfmux_idle(input int pin);
    case (pin)
      1:       pfmux_idle = 2'h3;
      4:       pfmux_idle = 2'h2;
      default: pfmux_idle = 2'h0;
    endcase
  endfunction

  function automatic int pfmux_reg_of(input int pin);
    if (pin < 8)       pfmux_reg_of = pin / 4;
    else if (pin < 12) pfmux_reg_of = 2;
    else if (pin < 14) pfmux_reg_of = 3;
    else if (pin < 18) pfmux_reg_of = 4;
    else               pfmux_reg_of = 5;
  endfunction

  function automatic int pfmux_fld_of(input int pin);
    if (pin < 8)       pfmux_fld_of = pin % 4;
    else if (pin < 12) pfmux_fld_of = pin - 8;
    else if (pin < 14) pfmux_fld_of = pin - 12;
    else if (pin < 18) pfmux_fld_of = pin - 14;
    else               pfmux_fld_of = pin - 18;
  endfunction

endpackage

// File: inc/pfmux_route_if.sv
/*
  Carrier between the register/flop top and the combinational pin router.
  Assumes both ends sit in the sys_clk domain.
*/
`timescale 1ns/100ps
interface pfmux_route_if;
  logic [2*pfmux_pkg::PIN_CNT-1:0] code;
  logic [pfmux_pkg::PIN_CNT-1:0]   pad_in;
  logic [pfmux_pkg::PIN_CNT-1:0]   gpio_out;
  logic [pfmux_pkg::PIN_CNT-1:0]   gpio_oe;
  logic [pfmux_pkg::PIN_CNT-1:0]   alt_a_out;
  logic [pfmux_pkg::PIN_CNT-1:0]   alt_a_oe;
  logic [pfmux_pkg::PIN_CNT-1:0]   alt_b_out;
  logic [pfmux_pkg::PIN_CNT-1:0]   alt_b_oe;
  logic [pfmux_pkg::PIN_CNT-1:0]   pad_out_d;
  logic [pfmux_pkg::PIN_CNT-1:0]   pad_oe_d;
  logic [pfmux_pkg::PIN_CNT-1:0]   gpio_in_d;
  logic [pfmux_pkg::PIN_CNT-1:0]   alt_a_in_d;
  logic [pfmux_pkg::PIN_CNT-1:0]   alt_b_in_d;

  modport ctrl  (output code, pad_in, gpio_out, gpio_oe, alt_a_out, alt_a_oe, alt_b_out, alt_b_oe,
                 input  pad_out_d, pad_oe_d, gpio_in_d, alt_a_in_d, alt_b_in_d);
  modport route (input  code, pad_in, gpio_out, gpio_oe, alt_a_out, alt_a_oe, alt_b_out, alt_b_oe,
                 output pad_out_d, pad_oe_d, gpio_in_d, alt_a_in_d, alt_b_in_d);
endinterface

// File: hw/pfmux_route.sv
/*
  Combinational per-pin router: picks port line or peripheral slot per code.
  Assumes the caller registers every result before it leaves the block.
*/
`timescale 1ns/100ps
module pfmux_route
(
  pfmux_route_if.route rt
);

  // ==========================================================================
  // Per-pin selection
  genvar g;
  generate
    for (g = 0; g < pfmux_pkg::PIN_CNT; g++)
    begin : g_pin
      localparam pfmux_pkg::pfmux_kind_e KIND = pfmux_pkg::pfmux_kind(g);
      localparam logic [1:0]             IDLE = pfmux_pkg::pfmux_idle(g);
      pfmux_pkg::pfmux_slot_e slot;
      wire sel_port;
      wire sel_a;
      wire sel_b;
      assign slot     = pfmux_pkg::pfmux_slot(KIND, rt.code[2*g +: 2]);
      assign sel_port = (slot == pfmux_pkg::SLOT_PORT);
      assign sel_a    = (slot == pfmux_pkg::SLOT_A);
      assign sel_b    = (slot == pfmux_pkg::SLOT_B);
      // Reserved codes release the pad rather than guess a function
      assign rt.pad_out_d[g]  = sel_port ? rt.gpio_out[g] : sel_a ? rt.alt_a_out[g] :
                                sel_b ? rt.alt_b_out[g] : 1'b0;
      assign rt.pad_oe_d[g]   = sel_port ? rt.gpio_oe[g] : sel_a ? rt.alt_a_oe[g] :
                                sel_b ? rt.alt_b_oe[g] : 1'b0;
      assign rt.gpio_in_d[g]  = sel_port & rt.pad_in[g];
      assign rt.alt_a_in_d[g] = sel_a ? rt.pad_in[g] : IDLE[0];
      assign rt.alt_b_in_d[g] = sel_b ? rt.pad_in[g] : IDLE[1];
    end
  endgenerate

endmodule // pfmux_route

// File: hw/pfmux_top.sv
/*
  Port 3 to 5 pin function mux: six byte-wide selector registers on APB
  and registered routing of pads to port lines or peripheral signals.
  Assumes APB master in the sys_clk domain and pads joined outside.
*/
`timescale 1ns/100ps

// Behaviour
// [R01] Pin 33: SPI2 clock, remote input, port
// [R02] Pin 32: clock out A, timer 4, port
// [R03] Pin 31: ADC trigger, bus-free request, port
// [R04] Pin 30: timer 0 or port only
// [R05] Pins 35-37 debug at 0, port at 1
// [R06] Pin 34: SPI1 select, remote output, port
// [R07] Pin 43: remote input, I2C slave data, port
// [R08] Pin 42: timer 1, UART0 clock, port
// [R09] Pin 41: timer 7, UART0 transmit, port
// [R10] Pin 40: UART0 receive, timer capture, port
// [R11] Pin 45: I2C master data, port plus ext clock
// [R12] Software disables pin 45 output before ext clock
// [R13] Pin 44: remote output, I2C slave clock, port
// [R14] Large variant: pins 50-53 to serial interface
// [R15] Large variant: pins 54-55 to serial interface
// [R16] Fields reset zero; reserved bits read zero
// [R17] Software avoids reserved codes; pin undefined
module pfmux_top
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [pfmux_pkg::PIN_CNT-1:0] pad_in,
  output logic      [pfmux_pkg::PIN_CNT-1:0] pad_out,
  output logic      [pfmux_pkg::PIN_CNT-1:0] pad_oe,
  input  wire logic [pfmux_pkg::PIN_CNT-1:0] gpio_out,
  input  wire logic [pfmux_pkg::PIN_CNT-1:0] gpio_oe,
  output logic      [pfmux_pkg::PIN_CNT-1:0] gpio_in,
  input  wire logic [pfmux_pkg::PIN_CNT-1:0] alt_a_out,
  input  wire logic [pfmux_pkg::PIN_CNT-1:0] alt_a_oe,
  output logic      [pfmux_pkg::PIN_CNT-1:0] alt_a_in,
  input  wire logic [pfmux_pkg::PIN_CNT-1:0] alt_b_out,
  input  wire logic [pfmux_pkg::PIN_CNT-1:0] alt_b_oe,
  output logic      [pfmux_pkg::PIN_CNT-1:0] alt_b_in,
  output logic                               timer0_ext_clock
);

  // ==========================================================================
  // Declarations
  logic [7:0]                     sel_q [pfmux_pkg::REG_CNT];
  logic [31:0]                    prdata_q;
  logic                           pready_q;
  logic                           pslverr_q;
  logic [pfmux_pkg::PIN_CNT-1:0]  pad_out_q;
  logic [pfmux_pkg::PIN_CNT-1:0]  pad_oe_q;
  logic [pfmux_pkg::PIN_CNT-1:0]  gpio_in_q;
  logic [pfmux_pkg::PIN_CNT-1:0]  alt_a_in_q;
  logic [pfmux_pkg::PIN_CNT-1:0]  alt_b_in_q;
  logic                           ext_clk_q;
  logic [7:0]                     rd_byte;
  logic [2:0]                     reg_num;
  wire  [29:0]                    word_idx;
  wire                            in_range;
  wire                            hit;
  wire                            access;
  wire                            first_acc;
  wire                            commit_wr;

  pfmux_route_if rif ();

  // ==========================================================================
  // APB decode
  // Answer in the second access cycle so pready can come from a flop
  assign word_idx  = paddr[31:2];
  assign in_range  = (word_idx >= pfmux_pkg::IDX_P3_LOW) && (word_idx <= pfmux_pkg::IDX_P5_UPPER);
  assign hit       = in_range && (paddr[1:0] == 2'b00);
  assign reg_num   = hit ? 3'(word_idx - pfmux_pkg::IDX_P3_LOW) : 3'h0;
  assign access    = psel && penable;
  assign first_acc = access && !pready_q;
  assign commit_wr = access && pready_q && pwrite && hit && pstrb[0];

  // Implemented bits per register; port 5 is absent on the small variant
  function automatic logic [7:0] wr_mask(input int r);
    logic [7:0] m;
    m = ((r == 3) || (r == 5)) ? pfmux_pkg::MASK_LOW_NIB : pfmux_pkg::MASK_FULL;
    if ((r >= pfmux_pkg::FIRST_P5_REG) && !LARGE_VARIANT)
      m = 8'h00;
    return m;
  endfunction

  always_comb
  begin
    rd_byte = 8'h00;
    if (hit)
      rd_byte = sel_q[reg_num] & wr_mask(int'(reg_num)); // R16
  end

  // ==========================================================================
  // Bus answer
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= first_acc;
      pslverr_q <= first_acc && !hit;
      if (first_acc && !pwrite)
        prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================================
  // Selector registers
  genvar r;
  generate
    for (r = 0; r < pfmux_pkg::REG_CNT; r++)
    begin : g_reg
      localparam logic [7:0] MASK = wr_mask(r);
      wire                   we;
      assign we = commit_wr && (reg_num == 3'(r));
      always_ff @(posedge sys_clk)
      begin
        if (srst)
          sel_q[r] <= pfmux_pkg::REG_RESET; // R16
        else if (we)
          sel_q[r] <= pwdata[7:0] & MASK;   // R16 R14 R15
      end
    end
  endgenerate

  // ==========================================================================
  // Routing codes to the router
  genvar p;
  generate
    for (p = 0; p < pfmux_pkg::PIN_CNT; p++)
    begin : g_code
      localparam int RI = pfmux_pkg::pfmux_reg_of(p);
      localparam int FI = pfmux_pkg::pfmux_fld_of(p);
      assign rif.code[2*p +: 2] = sel_q[RI][2*FI +: 2];
    end
  endgenerate

  assign rif.pad_in    = pad_in;
  assign rif.gpio_out  = gpio_out;
  assign rif.gpio_oe   = gpio_oe;
  assign rif.alt_a_out = alt_a_out;
  assign rif.alt_a_oe  = alt_a_oe;
  assign rif.alt_b_out = alt_b_out;
  assign rif.alt_b_oe  = alt_b_oe;

  pfmux_route u_route
  (
    .rt (rif.route)
  );

  // ==========================================================================
  // Registered pin outputs
  // One cycle of latency buys glitch-free pads while a field changes
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pad_out_q  <= '0;
      pad_oe_q   <= '0;
      gpio_in_q  <= '0;
      alt_a_in_q <= '0;
      alt_b_in_q <= '0;
    end
    else
    begin
      pad_out_q  <= rif.pad_out_d;  // R01 R02 R03 R04 R05 R06 R07
      pad_oe_q   <= rif.pad_oe_d;   // R08 R09 R10 R13 R17
      gpio_in_q  <= rif.gpio_in_d;
      alt_a_in_q <= rif.alt_a_in_d;
      alt_b_in_q <= rif.alt_b_in_d;
    end
  end

  // Timer external clock shares pin 45 with the port line; the port
  // output must already be disabled by software
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ext_clk_q <= 1'b0;
    else
      ext_clk_q <= (rif.code[2*pfmux_pkg::PIN_P45 +: 2] == pfmux_pkg::CODE_0) &&
                   pad_in[pfmux_pkg::PIN_P45]; // R11 R12
  end

  // ==========================================================================
  // Outputs
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign pad_out          = pad_out_q;
  assign pad_oe           = pad_oe_q;
  assign gpio_in          = gpio_in_q;
  assign alt_a_in         = alt_a_in_q;
  assign alt_b_in         = alt_b_in_q;
  assign timer0_ext_clock = ext_clk_q;

endmodule // pfmux_top

// File: verification/pfmux_monitor.sv
/*
  Checker for the pin function mux: shadows the selector codes from APB traffic
  and ties sampled routed outputs to their sources one cycle earlier.
  Assumes it is bound to pfmux_top and sees only that module's ports.
*/
`timescale 1ns/100ps
module pfmux_monitor
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [19:0] pad_in,
  input wire logic [19:0] pad_out,
  input wire logic [19:0] pad_oe,
  input wire logic [19:0] gpio_in,
  input wire logic [19:0] alt_a_out,
  input wire logic [19:0] alt_a_oe,
  input wire logic [19:0] alt_b_out,
  input wire logic [19:0] alt_b_oe,
  input wire logic [19:0] alt_a_in,
  input wire logic [19:0] alt_b_in,
  input wire logic        timer0_ext_clock
);
  // ==========================================================================
  // Shadow codes, committed at the same edge as the design's registers
  logic [7:0]  sh_q [6];
  wire  [29:0] idx = paddr[31:2] - pfmux_pkg::IDX_P3_LOW;
  wire         hit = paddr[1:0] == 2'h0 && idx < 30'd6 && (LARGE_VARIANT || idx < 30'd4);
  wire         wr  = psel && penable && pready && pwrite && pstrb[0] && hit;
  wire  [7:0]  msk = (idx == 30'd3 || idx == 30'd5) ? 8'h0f : 8'hff;
  wire  [39:0] cd  = {sh_q[5][3:0], sh_q[4], sh_q[3][3:0], sh_q[2], sh_q[1], sh_q[0]};

  always_ff @(posedge sys_clk)
    if (srst)
      sh_q <= '{default: 8'h00};
    else if (wr)
      sh_q[idx[2:0]] <= pwdata[7:0] & msk;

  // Outputs still show reset values one edge after release
  logic rst_q;
  always_ff @(posedge sys_clk)
    rst_q <= srst;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst || rst_q);

  // ==========================================================================
  // Routing, read data and pready length
  a_pin33_spi_clk: assert property (cd[7:6] == 2'h2 |=> pad_oe[3] == $past(alt_b_oe[3])) else $error("pin 33 route");
  a_pin32_timer_in: assert property (cd[5:4] == 2'h1 |=> alt_a_in[2] == $past(pad_in[2])) else $error("pin 32 route");
  a_pin31_idle_high: assert property (cd[3:2] == 2'h0 |=> alt_a_in[1] && alt_b_in[1]) else $error("pin 31 idle");
  a_pin30_timer_out: assert property (cd[1:0] == 2'h1 |=> pad_out[0] == $past(alt_a_out[0])) else $error("pin 30");
  a_debug_default: assert property (cd[11:10] == 2'h0 |=> pad_oe[5] == $past(alt_a_oe[5]) && !gpio_in[5]) else $error("pin 35");
  a_pin34_select: assert property (cd[9:8] == 2'h2 |=> alt_b_in[4] == $past(pad_in[4])) else $error("pin 34 route");
  a_pin43_remote: assert property (cd[23:22] == 2'h2 |=> alt_b_in[11] == $past(pad_in[11])) else $error("pin 43");
  a_ext_clock_pass: assert property (cd[27:26] == 2'h0 |=> timer0_ext_clock == $past(pad_in[13])) else $error("ext clk");
  a_pin44_i2c_clk: assert property (cd[25:24] == 2'h1 |=> pad_out[12] == $past(alt_a_out[12])) else $error("pin 44");
  a_serial_route: assert property (cd[29:28] == 2'h1 |=> pad_oe[14] == $past(alt_a_oe[14])) else $error("pin 50");
  a_read_match: assert property (pready && !pwrite && !pslverr |-> prdata == {24'h0, sh_q[idx[2:0]]}) else $error("read");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready length");

  c_spi_clk: cover property (cd[7:6] == 2'h2);
  c_bus_error: cover property (pready && pslverr);
  c_i2c_data: cover property (cd[27:26] == 2'h1);
  c_reserved_code: cover property (cd[7:6] == 2'h3);
endmodule // pfmux_monitor

bind pfmux_top pfmux_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) u_pfmux_monitor (.*);

// File: verification/pfmux_far_side.sv
/*
  Far-side model: pads, port lines and peripherals with fresh values each cycle.
  Assumes the bench steers the external clock mode of pin 45.
*/
`timescale 1ns/100ps
module pfmux_far_side
(
  input  wire logic        sys_clk,
  input  wire logic        ext_mode,
  output logic      [19:0] pad_in,
  output logic      [19:0] gpio_out,
  output logic      [19:0] gpio_oe,
  output logic      [19:0] alt_a_out,
  output logic      [19:0] alt_a_oe,
  output logic      [19:0] alt_b_out,
  output logic      [19:0] alt_b_oe
);
  initial {pad_in, gpio_out, gpio_oe, alt_a_out, alt_a_oe, alt_b_out, alt_b_oe} = 140'h0;
  // Changing every cycle so a stale or crossed route cannot match by luck
  always @(posedge sys_clk)
  begin
    pad_in    <= 20'($urandom);
    gpio_out  <= 20'($urandom);
    gpio_oe   <= 20'($urandom) & (ext_mode ? 20'hfdfff : 20'hfffff);
    alt_a_out <= 20'($urandom);
    alt_a_oe  <= 20'($urandom);
    alt_b_out <= 20'($urandom);
    alt_b_oe  <= 20'($urandom);
  end
endmodule // pfmux_far_side

// File: verification/test_port3_to_5_pin_function_mux.sv
/*
  Bench for the pin function mux: APB master, per-cycle routing model.
  Assumes the default large variant and one 125 MHz clock.
*/
`timescale 1ns/100ps
module test_port3_to_5_pin_function_mux;
  localparam logic [31:0] BASE = {pfmux_pkg::IDX_P3_LOW, 2'h0};
  localparam logic [19:0] HASB = 20'h01f1e;
  localparam logic [19:0] DBG  = 20'h000e0;
  localparam logic [19:0] IDA  = 20'h00002;
  localparam logic [19:0] IDB  = 20'h00012;
  localparam int          PB [6] = '{0, 4, 8, 12, 14, 18};
  logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, timer0_ext_clock, ext_mode, rs_c;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic [19:0] pad_in, pad_out, pad_oe, gpio_out, gpio_oe, gpio_in, alt_a_out, alt_a_oe, alt_a_in;
  logic [19:0] alt_b_out, alt_b_oe, alt_b_in, pi_c, go_c, ge_c, ao_c, ae_c, bo_c, be_c;
  logic [39:0] cd_c;
  logic [7:0]  sh [6];
  int          fail_count = 0;
  int          n_checks = 0;
  int          r;

  pfmux_top      u_pfmux_top (.*);
  pfmux_far_side u_pfmux_far_side (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Reserved codes become code 0; software must not select them
  function automatic logic [7:0] legal(input int rg, input logic [7:0] d);
    legal = d;
    for (int k = 0; k < 4; k++)
      if (d[2*k+:2] == 2'h3 || (d[2*k+:2] == 2'h2 && HASB[PB[rg]+k] !== 1'b1)) legal[2*k+:2] = 2'h0;
  endfunction

  // ==========================================================================
  // APB master: one transfer, released unless the next follows at once
  task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d, input logic [3:0] st, input bit keep);
    int          n;
    logic        ok;
    logic [29:0] ix;
    ix = a[31:2] - pfmux_pkg::IDX_P3_LOW;
    ok = a[1:0] == 2'h0 && ix < 30'd6;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= st;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50) fail_count++;
    check("pready wait", n, 1);
    if (!wr) check("prdata", prdata, ok ? {24'h0, sh[ix[2:0]]} : 32'h0);
    check("pslverr", {31'h0, pslverr}, {31'h0, !ok});
    if (wr && ok && st[0]) sh[ix[2:0]] <= d & ((ix == 30'd3 || ix == 30'd5) ? 8'h0f : 8'hff);
    penable <= 1'b0;
    if (!keep)
    begin
      psel <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  // ==========================================================================
  // Routing model: inputs and codes taken at an edge give the outputs after it
  always @(posedge sys_clk)
  begin
    cd_c <= {sh[5][3:0], sh[4], sh[3][3:0], sh[2], sh[1], sh[0]};
    {pi_c, go_c, ge_c, ao_c, ae_c, bo_c, be_c, rs_c} <= {pad_in, gpio_out, gpio_oe, alt_a_out, alt_a_oe,
                                                         alt_b_out, alt_b_oe, srst};
  end

  always @(negedge sys_clk)
    if (rs_c === 1'b0)
      route_chk();

  task automatic route_chk();
    logic [19:0] eo, ee, eg, ea, eb, m;
    logic [1:0]  c, s;
    for (int i = 0; i < 20; i++)
    begin
      c = cd_c[2*i+:2];
      s = DBG[i] ? (c == 2'h0 ? 2'h1 : c == 2'h1 ? 2'h0 : 2'h3) : (c == 2'h2 && !HASB[i]) ? 2'h3 : c;
      eo[i] = s == 2'h0 ? go_c[i] : s == 2'h1 ? ao_c[i] : bo_c[i];
      ee[i] = s == 2'h0 ? ge_c[i] : s == 2'h1 ? ae_c[i] : s == 2'h2 ? be_c[i] : 1'b0;
      eg[i] = s == 2'h0 && pi_c[i];
      ea[i] = s == 2'h1 ? pi_c[i] : IDA[i];
      eb[i] = s == 2'h2 ? pi_c[i] : IDB[i];
      m[i] = s != 2'h3;
    end
    check("pad_out", {12'h0, pad_out & m}, {12'h0, eo & m});
    check("pad_oe", {12'h0, pad_oe}, {12'h0, ee});
    check("gpio_in", {12'h0, gpio_in}, {12'h0, eg});
    check("alt_a_in", {12'h0, alt_a_in}, {12'h0, ea});
    check("alt_b_in", {12'h0, alt_b_in}, {12'h0, eb});
    check("timer0_ext_clock", {31'h0, timer0_ext_clock}, {31'h0, cd_c[27:26] == 2'h0 && pi_c[13]});
  endtask

  initial
  begin
    srst = 1'b1;
    {psel, penable, pwrite, ext_mode} = 4'h0;
    {paddr, pwdata, pstrb} = 68'h0;
    sh = '{default: 8'h00};
    void'($urandom(32'h026a));
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (r = 0; r < 6; r++) apb(1'b0, BASE + 4 * r, 8'h00, 4'hf, 1'b0);
    // Every legal code of every pin, then hold so the model sees each setting
    for (int c = 0; c < 3; c++)
      for (r = 0; r < 6; r++) apb(1'b1, BASE + 4 * r, legal(r, {4{2'(c)}}), 4'h1, r < 5);
    repeat (4) @(posedge sys_clk);
    // Random codes and strobes, each write read back at once
    repeat (80)
    begin
      r = $urandom_range(5);
      ext_mode <= sh[3][3:2] == 2'h0;
      apb(1'b1, BASE + 4 * r, legal(r, 8'($urandom)), 4'($urandom), 1'b1);
      apb(1'b0, BASE + 4 * r, 8'h00, 4'h0, 1'b0);
    end
    apb(1'b0, BASE + 24, 8'h00, 4'h0, 1'b0);
    apb(1'b1, BASE + 1, 8'h55, 4'h1, 1'b0);
    apb(1'b1, BASE + 12, 8'hf5, 4'h1, 1'b0);
    apb(1'b0, BASE + 12, 8'h00, 4'h0, 1'b0);
    // Reserved codes on debug pins, pin 45 and pin 30 release the pad
    apb(1'b1, BASE + 4, 8'hb0, 4'h1, 1'b0);
    apb(1'b1, BASE + 12, 8'h08, 4'h1, 1'b0);
    apb(1'b1, BASE, 8'hc2, 4'h1, 1'b0);
    repeat (4) @(posedge sys_clk);
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end
endmodule // test_port3_to_5_pin_function_mux
